// ---- src/ubsm_mapper.sv ----
`timescale 1ns/100ps
module ubsm_mapper #(
    parameter int DEPTH = 2048
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // avalon-mm slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    // serial burst bits in
    input  wire logic               bit_data,
    input  wire logic               bit_valid,
    output logic                    bit_ready,
    // shaped baseband and modulated output
    output logic signed [13:0]      shaped_i,
    output logic signed [13:0]      shaped_q,
    output logic signed [22:0]      tx_sample,
    output logic                    tx_active
);
    localparam int CW = $clog2(DEPTH) + 1;

    if (DEPTH < 4 || DEPTH > 65535) begin : g_chk
        $error("ubsm_mapper: DEPTH out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one quarter turn of the quadrant label
    function automatic logic [1:0] rot90(input logic [1:0] q);
        case (q)
            2'b11:   rot90 = 2'b01;
            2'b01:   rot90 = 2'b00;
            2'b00:   rot90 = 2'b10;
            default: rot90 = 2'b11;
        endcase
    endfunction

    // input high bits 00,01,11,10 give 0..3 quarter turns
    function automatic logic [1:0] rotate(input logic [1:0] q, input logic [1:0] h);
        logic [1:0] n;
        logic [1:0] r;
        n = {h[1], h[1] ^ h[0]};
        r = q;
        for (int k = 0; k < 3; k++) begin
            if (k < int'(n)) begin
                r = rot90(r);
            end
        end
        rotate = r;
    endfunction

    // gray square grid: sign bit then magnitude bit, 11,10,00,01 = -3,-1,+1,+3
    function automatic logic signed [3:0] level(input logic s, input logic m, input logic qam16);
        logic signed [3:0] a;
        a = qam16 ? (m ? 4'sh3 : 4'sh1) : 4'sh2;
        level = s ? -a : a;
    endfunction

    function automatic logic signed [7:0] sine16(input logic [3:0] p);
        logic [2:0] k;
        logic [7:0] t;
        k = p[2] ? 3'(5'd8 - {2'b00, p[2:0]}) : p[2:0];
        case (k)
            3'h0:    t = 8'h00;
            3'h1:    t = 8'h31;
            3'h2:    t = 8'h5A;
            3'h3:    t = 8'h75;
            default: t = 8'h7F;
        endcase
        sine16 = p[3] ? -$signed(t) : $signed(t);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ubsm_pkg::ubsm_state_t state;
    ubsm_pkg::ubsm_state_t next_state;
    ubsm_pkg::ubsm_cfg_t   cfg_pend;
    ubsm_pkg::ubsm_cfg_t   cfg;
    ubsm_pkg::ubsm_sym_t   fifo [0:1];
    ubsm_pkg::ubsm_sym_t   map_sym;
    logic                  mem [0:DEPTH-1];
    logic [CW-1:0]         wr_cnt;
    logic [CW-1:0]         next_wr_cnt;
    logic [CW-1:0]         rd_ptr;
    logic [1:0]            fifo_cnt;
    logic [1:0]            prev_quad;
    logic [1:0]            quad;
    logic [3:0]            nib;
    logic [2:0]            rate_pend;
    logic [2:0]            rate_act;
    logic signed [16:0]    freq_off;
    logic [15:0]           tx_slot;
    logic [15:0]           slot_cnt;
    logic [7:0]            grid_cnt;
    logic [8:0]            tick_acc;
    logic [6:0]            tick_inc;
    logic [1:0]            phase4;
    logic [31:0]           nco;
    logic signed [40:0]    nco_prod;
    logic signed [3:0]     line_i [0:ubsm_pkg::RRC_LEN-1];
    logic signed [3:0]     line_q [0:ubsm_pkg::RRC_LEN-1];
    logic signed [13:0]    sum_i;
    logic signed [13:0]    sum_q;
    logic                  arm_wr;
    logic                  freq_wr;
    logic                  bus_wr;
    logic                  grid_wrap;
    logic                  tick4;
    logic                  sym_tick;
    logic                  map_en;
    logic                  push;
    logic                  pop;
    logic                  bit_take;

    assign bus_wr    = avs_write && !avs_waitrequest;
    assign arm_wr    = bus_wr && avs_address == ubsm_pkg::OFS_CTRL && avs_writedata[ubsm_pkg::CTRL_ARM];
    assign freq_wr   = bus_wr && avs_address == ubsm_pkg::OFS_FREQ;
    assign grid_wrap = grid_cnt == 8'(ubsm_pkg::GRID_CYC - 1);
    assign tick_inc  = 7'(ubsm_pkg::TICK_INC_MAX >> rate_act);
    assign tick4     = tick_acc < {2'b00, tick_inc};
    assign sym_tick  = tick4 && phase4 == 2'd0;
    assign map_en    = state != ubsm_pkg::UBSM_LOAD && rd_ptr < wr_cnt;
    assign push      = map_en && fifo_cnt != 2'd2; // a full buffer stalls the mapper
    assign pop       = sym_tick && state == ubsm_pkg::UBSM_SEND && fifo_cnt != 2'd0;
    assign bit_take  = bit_valid && bit_ready;

    // ------------------------------------------------------------
    // avalon slave: one wait cycle on every access
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    ubsm_pkg::OFS_CTRL:   avs_readdata <= {30'h0, cfg_pend.diff, cfg_pend.qam16};
                    ubsm_pkg::OFS_STATUS: avs_readdata <= (32'(wr_cnt) << ubsm_pkg::STAT_CNT)
                                              | (32'(state == ubsm_pkg::UBSM_SEND) << ubsm_pkg::STAT_SEND)
                                              | (32'(state == ubsm_pkg::UBSM_ARMED) << ubsm_pkg::STAT_ARMED);
                    ubsm_pkg::OFS_RATE:   avs_readdata <= {29'h0, rate_act};
                    ubsm_pkg::OFS_FREQ:   avs_readdata <= 32'(freq_off);
                    ubsm_pkg::OFS_SLOT:   avs_readdata <= {16'h0, tx_slot};
                    ubsm_pkg::OFS_NOW:    avs_readdata <= {16'h0, slot_cnt};
                    default:              avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration registers; rate only takes effect with a frequency write
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg_pend  <= '0;
            rate_pend <= ubsm_pkg::RATE_RST;
            rate_act  <= ubsm_pkg::RATE_RST;
            freq_off  <= ubsm_pkg::FREQ_RST;
            tx_slot   <= ubsm_pkg::SLOT_RST;
        end else if (bus_wr) begin
            case (avs_address)
                ubsm_pkg::OFS_CTRL: begin
                    cfg_pend.qam16 <= avs_writedata[ubsm_pkg::CTRL_QAM16];
                    cfg_pend.diff  <= avs_writedata[ubsm_pkg::CTRL_DIFF];
                end
                ubsm_pkg::OFS_RATE: begin
                    if (avs_writedata[2:0] <= 3'(ubsm_pkg::RATE_MAX)) begin
                        rate_pend <= avs_writedata[2:0];
                    end
                end
                ubsm_pkg::OFS_FREQ: begin
                    freq_off <= avs_writedata[16:0];
                    rate_act <= rate_pend;
                end
                ubsm_pkg::OFS_SLOT: tx_slot <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // burst sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ubsm_pkg::UBSM_LOAD:  if (arm_wr && wr_cnt != '0) next_state = ubsm_pkg::UBSM_ARMED;
            ubsm_pkg::UBSM_ARMED: if (grid_wrap && slot_cnt + 16'h1 == tx_slot) begin
                next_state = ubsm_pkg::UBSM_SEND;
            end
            ubsm_pkg::UBSM_SEND:  if (!map_en && fifo_cnt == 2'd0) next_state = ubsm_pkg::UBSM_LOAD;
            default:              next_state = ubsm_pkg::UBSM_LOAD;
        endcase
        next_wr_cnt = wr_cnt;
        if (state == ubsm_pkg::UBSM_SEND && next_state == ubsm_pkg::UBSM_LOAD) begin
            next_wr_cnt = '0;
        end else if (bit_take) begin
            next_wr_cnt = wr_cnt + 1'b1;
        end
    end

    // burst bits are only taken while loading; whole burst stored before sending
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state     <= ubsm_pkg::UBSM_LOAD;
            wr_cnt    <= '0;
            bit_ready <= 1'b0;
            cfg       <= '0;
        end else begin
            state     <= next_state;
            wr_cnt    <= next_wr_cnt;
            bit_ready <= next_state == ubsm_pkg::UBSM_LOAD && next_wr_cnt < CW'(DEPTH);
            // take the mode from the arming write itself; cfg_pend only updates on this same edge
            if (arm_wr && state == ubsm_pkg::UBSM_LOAD) begin
                cfg.qam16 <= avs_writedata[ubsm_pkg::CTRL_QAM16]; // latched per burst
                cfg.diff  <= avs_writedata[ubsm_pkg::CTRL_DIFF];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (bit_take) begin
            mem[wr_cnt[CW-2:0]] <= bit_data;
        end
    end

    // ------------------------------------------------------------
    // symbol mapping
    // ------------------------------------------------------------
    always_comb begin
        nib = 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (rd_ptr + CW'(k) < wr_cnt) begin
                nib[3-k] = mem[(rd_ptr[CW-2:0] + (CW-1)'(k))]; // first bit lands in msb
            end
        end
        quad = cfg.diff ? rotate(prev_quad, nib[3:2]) : nib[3:2];
        map_sym.i = level(quad[1], nib[1], cfg.qam16);
        map_sym.q = level(quad[0], nib[0], cfg.qam16);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rd_ptr    <= '0;
            prev_quad <= 2'b00;
        end else if (state == ubsm_pkg::UBSM_LOAD) begin
            rd_ptr    <= '0;
            prev_quad <= 2'b00; // each burst starts from a known quadrant
        end else if (push) begin
            rd_ptr    <= rd_ptr + (cfg.qam16 ? CW'(4) : CW'(2));
            prev_quad <= quad;
        end
    end

    // two-entry buffer between mapper and shaper
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            fifo_cnt <= 2'd0;
            fifo[0]  <= '0;
            fifo[1]  <= '0;
        end else begin
            if (pop) begin
                fifo[0] <= (fifo_cnt == 2'd2) ? fifo[1] : map_sym;
            end else if (push && fifo_cnt == 2'd0) begin
                fifo[0] <= map_sym;
            end
            if (push && (fifo_cnt == 2'd1 && !pop || fifo_cnt == 2'd2)) begin
                fifo[1] <= map_sym;
            end
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // burst grid and sample ticks
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn || freq_wr) begin
            grid_cnt <= 8'h00;
            slot_cnt <= 16'h0000;
            tick_acc <= 9'h000;
            phase4   <= 2'd0;
        end else if (grid_wrap) begin
            grid_cnt <= 8'h00;
            slot_cnt <= slot_cnt + 16'h1;
            tick_acc <= 9'h000;
            phase4   <= 2'd0;
        end else begin
            grid_cnt <= grid_cnt + 8'h01;
            tick_acc <= (tick_acc + 9'(tick_inc) >= 9'(ubsm_pkg::GRID_CYC))
                        ? tick_acc + 9'(tick_inc) - 9'(ubsm_pkg::GRID_CYC)
                        : tick_acc + 9'(tick_inc);
            phase4   <= phase4 + {1'b0, tick4};
        end
    end

    // ------------------------------------------------------------
    // pulse shaping; zeros keep flowing so tails overlap the next burst
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int k = 0; k < ubsm_pkg::RRC_LEN; k++) begin
                line_i[k] <= 4'sh0;
                line_q[k] <= 4'sh0;
            end
        end else if (tick4) begin
            line_i[0] <= pop ? fifo[0].i : 4'sh0;
            line_q[0] <= pop ? fifo[0].q : 4'sh0;
            for (int k = 1; k < ubsm_pkg::RRC_LEN; k++) begin
                line_i[k] <= line_i[k-1];
                line_q[k] <= line_q[k-1];
            end
        end
    end

    always_comb begin
        sum_i = 14'sh0;
        sum_q = 14'sh0;
        for (int k = 0; k < ubsm_pkg::RRC_LEN; k++) begin
            sum_i = sum_i + 14'(line_i[k]) * 14'(ubsm_pkg::RRC_TAP[k < 8 ? 8 - k : k - 8]);
            sum_q = sum_q + 14'(line_q[k]) * 14'(ubsm_pkg::RRC_TAP[k < 8 ? 8 - k : k - 8]);
        end
    end

    // ------------------------------------------------------------
    // carrier offset and quadrature combining
    // ------------------------------------------------------------
    assign nco_prod = 41'(freq_off) * ubsm_pkg::NCO_K; // sub-hertz error over the range

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            nco       <= 32'h0000_0000;
            shaped_i  <= 14'sh0;
            shaped_q  <= 14'sh0;
            tx_sample <= 23'sh0;
            tx_active <= 1'b0;
        end else begin
            nco       <= nco + nco_prod[39:8];
            shaped_i  <= sum_i;
            shaped_q  <= sum_q;
            // 16-step carrier table trades spur level for area
            tx_sample <= 23'(shaped_i) * 23'(sine16(nco[31:28] + 4'h4))
                       - 23'(shaped_q) * 23'(sine16(nco[31:28]));
            tx_active <= state == ubsm_pkg::UBSM_SEND;
        end
    end

endmodule

// ---- src/ubsm_pkg.sv ----
package ubsm_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 40_000_000;
    localparam int GRID_NS      = 6250;                      // burst start grid, ns
    localparam int GRID_CYC     = GRID_NS / (1_000_000_000 / CLK_HZ);
    localparam int SYM_PER_GRID = 16;                        // at the fastest rate
    localparam int SPS          = 4;                         // shaper samples per symbol
    localparam int TICK_INC_MAX = SYM_PER_GRID * SPS;        // sample ticks per grid
    localparam int RATE_MAX     = 4;                         // 0 = 2560 ... 4 = 160 ksym/s

    // ------------------------------------------------------------
    // register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RATE   = 5'h08;
    localparam logic [4:0] OFS_FREQ   = 5'h0C;
    localparam logic [4:0] OFS_SLOT   = 5'h10;
    localparam logic [4:0] OFS_NOW    = 5'h14;

    // field positions
    localparam int CTRL_QAM16 = 0;
    localparam int CTRL_DIFF  = 1;
    localparam int CTRL_ARM   = 2;
    localparam int STAT_ARMED = 0;
    localparam int STAT_SEND  = 1;
    localparam int STAT_CNT   = 16;

    // reset values
    localparam logic [2:0]  RATE_RST = 3'h4;
    localparam logic [16:0] FREQ_RST = 17'h00000;
    localparam logic [15:0] SLOT_RST = 16'h0000;

    // ------------------------------------------------------------
    // carrier offset oscillator: increment = freq * 2^40 / clk >> 8
    // ------------------------------------------------------------
    localparam longint NCO_K_L = ((64'd1 << 40) + CLK_HZ / 2) / CLK_HZ;
    localparam logic signed [40:0] NCO_K = 41'(NCO_K_L);

    // root raised cosine, 25 % excess bandwidth, 4 sps, half of 17 taps
    localparam logic signed [7:0] RRC_TAP [0:8] = '{8'sh40, 8'sh38, 8'sh25, 8'sh0E,
                                                    -8'sh04, -8'sh0C, -8'sh0A, -8'sh03, 8'sh03};
    localparam int RRC_LEN = 17;

    typedef enum {UBSM_LOAD, UBSM_ARMED, UBSM_SEND} ubsm_state_t;

    typedef struct packed {
        logic signed [3:0] i;
        logic signed [3:0] q;
    } ubsm_sym_t;

    typedef struct packed {
        logic qam16;
        logic diff;
    } ubsm_cfg_t;

endpackage

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
    localparam int DEPTH = 16;
    logic               core_clk        = 1'b0;
    logic               resetn          = 1'b0;
    logic [4:0]         avs_address     = 5'h00;
    logic               avs_read        = 1'b0;
    logic               avs_write       = 1'b0;
    logic [31:0]        avs_writedata   = 32'h0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               bit_data        = 1'b0;
    logic               bit_valid       = 1'b0;
    logic               bit_ready;
    logic signed [13:0] shaped_i;
    logic signed [13:0] shaped_q;
    logic signed [22:0] tx_sample;
    logic               tx_active;
    logic [15:0]        burst_len;
    logic [15:0]        gap_len;
    logic               heard;
    logic [31:0]        rd;
    int                 errors          = 0;
    int                 samples_checked = 0;
    int                 cyc             = 0;
    int                 phase           = -1;
    logic [4:0]         ofs [6]         = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};

    ubsm_mapper #(.DEPTH(DEPTH)) dut_u (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .bit_data, .bit_valid, .bit_ready,
        .shaped_i, .shaped_q, .tx_sample, .tx_active);
    ubsm_headend_rx rx_u (.core_clk, .resetn, .tx_sample, .tx_active, .burst_len, .gap_len, .heard);

    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // a hang anywhere ends here, so every wait below may be unbounded
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address   <= adr;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // first bit of the word goes first, so it lands in the first symbol's top bit
    task automatic load(input logic [15:0] pat);
        bit_valid <= 1'b1;
        for (int k = DEPTH - 1; k >= 0; k--) begin
            bit_data <= pat[k];
            do @(posedge core_clk); while (bit_ready !== 1'b1);
        end
        bit_valid <= 1'b0;
    endtask

    task automatic burst(input logic [2:0] rate, input logic qam, input logic diff);
        logic [15:0] exp;
        int          t0;
        // first symbol leaves on the first sending cycle, so the burst spans n-1 symbol periods plus two
        exp = 16'(((qam ? 4 : 8) - 1) * (250 << rate) / 16 + 2);
        bus(1'b1, ubsm_pkg::OFS_RATE, {29'h0, rate});
        bus(1'b1, ubsm_pkg::OFS_FREQ, 32'h0001_8300);
        t0 = cyc;
        bus(1'b0, ubsm_pkg::OFS_RATE, 32'h0);
        `CHK(rd[2:0], rate)
        bus(1'b0, ubsm_pkg::OFS_FREQ, 32'h0);
        `CHK(rd[16:0], 17'h18300)
        load(16'hB4E1);
        bus(1'b0, ubsm_pkg::OFS_STATUS, 32'h0);
        `CHK({bit_ready, rd[31:16]}, {1'b0, 16'(DEPTH)})
        bus(1'b1, ubsm_pkg::OFS_SLOT, 32'h2);
        bus(1'b1, ubsm_pkg::OFS_CTRL, {29'h0, 1'b1, diff, qam});
        while (tx_active !== 1'b1) @(posedge core_clk);
        if (phase < 0) phase = (cyc - t0) % 250;
        `CHK((cyc - t0) % 250, phase)
        bus(1'b0, ubsm_pkg::OFS_STATUS, 32'h0);
        `CHK(rd[1:0], 2'h2)
        while (tx_active !== 1'b0) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        `CHK(burst_len + 16'h4 >= exp && burst_len <= exp + 16'h4, 1'b1)
        `CHK(heard, 1'b1)
        bus(1'b0, ubsm_pkg::OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0)
        $display("burst rate %0d qam16 %0d done", rate, qam);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        // reset values, the last address is unmapped
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, ofs[k], 32'h0);
            `CHK(rd, (k == 2) ? {29'h0, ubsm_pkg::RATE_RST} : 32'h0)
        end
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus(1'b1, ubsm_pkg::OFS_RATE, 32'h7);
        bus(1'b1, ubsm_pkg::OFS_FREQ, 32'h0);
        bus(1'b0, ubsm_pkg::OFS_RATE, 32'h0);
        `CHK(rd, {29'h0, ubsm_pkg::RATE_RST})
        bus(1'b1, ubsm_pkg::OFS_RATE, 32'h0);
        bus(1'b0, ubsm_pkg::OFS_RATE, 32'h0);
        `CHK(rd, {29'h0, ubsm_pkg::RATE_RST})
        $display("test registers done");
        // every rate in both modes, differential on odd rates
        for (int m = 1; m >= 0; m--) begin
            for (int r = 0; r < 5; r++) burst(3'(r), m[0], r[0]);
        end
        tally_and_finish();
    end
endmodule

// ---- tb/ubsm_headend_rx.sv ----
`timescale 1ns/100ps
module ubsm_headend_rx (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               resetn,
    // modulated burst from the modem
    input  wire logic signed [22:0] tx_sample,
    input  wire logic               tx_active,
    // what the receiver saw of the last burst
    output logic             [15:0] burst_len,
    output logic             [15:0] gap_len,
    output logic                    heard
);
    logic        was_active;
    logic [15:0] run_cnt;

    // burst and silence lengths; the scheduler keeps gaps above two symbols
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            was_active <= 1'b0;
            run_cnt    <= 16'h0000;
            burst_len  <= 16'h0000;
            gap_len    <= 16'h0000;
            heard      <= 1'b0;
        end else begin
            was_active <= tx_active;
            if (tx_active != was_active) begin
                run_cnt <= 16'h0001;
                if (tx_active) gap_len <= run_cnt;
                else burst_len <= run_cnt;
            end else begin
                run_cnt <= run_cnt + 16'h0001;
            end
            // energy only counts inside a burst; tails between bursts are allowed
            if (tx_active && !was_active) heard <= 1'b0;
            else if (tx_active && tx_sample != 23'sh0) heard <= 1'b1;
        end
    end
endmodule

// ---- tb/ubsm_mapper_monitor.sv ----
`timescale 1ns/100ps
module ubsm_mapper_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // bit stream and burst state
    input wire logic        bit_valid,
    input wire logic        bit_ready,
    input wire logic        tx_active
);
    // ------------------------------------------------------------
    // one clock domain, checks idle during reset
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // a taken request is answered on the very next edge
    answer_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    // the answer lasts one cycle only, so a held request is not taken twice
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");
    hole_read_a: assert property (avs_read && avs_address == 5'h18 && !avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("unmapped read returned data");
    data_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
        else $error("read data changed between accesses");
    // outputs leave reset quiet; loading opens one edge later
    release_state_a: assert property ($rose(resetn) |-> avs_waitrequest && !bit_ready && !tx_active ##1 bit_ready)
        else $error("wrong state after reset release");
    start_locked_a: assert property ($rose(tx_active) |-> !bit_ready)
        else $error("bits accepted while a burst starts");
    // a burst of two or more symbols at the fastest rate spans more than eight cycles; a one-symbol burst spans two
    min_burst_a: assert property ($rose(tx_active) |=> tx_active [*8])
        else $error("burst shorter than one symbol");
    reload_a: assert property ($fell(tx_active) |-> ##[0:3] bit_ready)
        else $error("loading not reopened after burst");

    cover property ($rose(tx_active));
    cover property (bit_valid && !bit_ready && !tx_active);
    cover property (avs_write && avs_address == ubsm_pkg::OFS_FREQ && !avs_waitrequest);
endmodule

bind ubsm_mapper ubsm_mapper_monitor mon_u (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .bit_valid, .bit_ready, .tx_active);
